// >>> design/qpv_defs.svh
`ifndef QPV_DEFS_SVH
`define QPV_DEFS_SVH
// ----------------------------------------------------------------
// Link geometry
// ----------------------------------------------------------------
`define QPV_PORTS 4
`define QPV_WORD_W 35
`define QPV_CODE_W 10
`define QPV_PV_BIT 20
`define QPV_VS_BIT 19
`define QPV_HS_BIT 18
// ----------------------------------------------------------------
// Frame geometry
// ----------------------------------------------------------------
`define QPV_LINE_PIX 1920
`define QPV_ACT_LINES 1080
`define QPV_LINE_ACT_CLK 480
`define QPV_HBLANK_MAX 95
`define QPV_HBLANK_NOM 70
`define QPV_VBLANK_NOM 45
`define QPV_FIFO_DEPTH 8
// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define QPV_CLK_HZ 200000000
`define QPV_LOW_RATE_MIN_HZ 97
`define QPV_LOW_RATE_MAX_HZ 103
`define QPV_HIGH_RATE_MIN_HZ 117
`define QPV_HIGH_RATE_MAX_HZ 123
`define QPV_LINK_DIV 16
`endif

// >>> design/qpv_pkg.sv
`include "qpv_defs.svh"
package qpv_pkg;
  typedef struct packed {
    logic [`QPV_CODE_W-1:0] red;
    logic [`QPV_CODE_W-1:0] green;
    logic [`QPV_CODE_W-1:0] blue;
  } qpv_pix_s;

  typedef logic [`QPV_WORD_W-1:0] qpv_word_t;

  typedef enum logic [1:0] {
    QPV_OFF = 2'b00,
    QPV_IDLE = 2'b01,
    QPV_RUN = 2'b10
  } qpv_mode_e;

  typedef struct packed {
    logic [3:0] ck1;
    logic [3:0] ck2;
    logic [3:0] ck3;
    logic [3:0] ckq;
    logic [3:0][`QPV_WORD_W-1:0] d1;
    logic [3:0][`QPV_WORD_W-1:0] d2;
    logic [3:0][`QPV_WORD_W-1:0] d3;
    logic [2:0] fmt_s;
    logic [2:0] rate_s;
    logic fmt_q;
    logic rate_q;
    logic [7:0] blank;
    logic vblank;
    logic seen;
    logic [21:0] per;
    logic [1:0] rr;
    logic [10:0] x;
    logic [10:0] y;
    logic vld;
    logic sof;
    qpv_pix_s pix;
    logic ovf;
    logic rerr;
  } qpv_rx_s;

  typedef struct packed {
    qpv_mode_e mode;
    logic [3:0] div;
    logic lclk;
    logic [9:0] h;
    logic [10:0] v;
    logic [2:0] fill;
    qpv_pix_s [3:0] grp;
    logic [3:0][`QPV_WORD_W-1:0] word;
    logic fmt_o;
    logic rate_o;
    logic rdy;
    logic urun;
    logic fpulse;
    logic bl;
  } qpv_tx_s;

  // Spare, hsync and vsync positions are always sent low.
  function automatic qpv_word_t qpv_pack(input logic vesa, input qpv_pix_s p,
                                         input logic pv);
    qpv_word_t w;
    w = '0;
    w[`QPV_PV_BIT] = pv;
    if (vesa)
    begin
      w[5:0] = p.red[7:2];
      w[6] = p.green[2];
      w[11:7] = p.green[7:3];
      w[13:12] = p.blue[3:2];
      w[17:14] = p.blue[7:4];
      w[22:21] = p.red[9:8];
      w[24:23] = p.green[9:8];
      w[26:25] = p.blue[9:8];
    end
    else
    begin
      w[5:0] = p.red[9:4];
      w[6] = p.green[4];
      w[11:7] = p.green[9:5];
      w[13:12] = p.blue[5:4];
      w[17:14] = p.blue[9:6];
      w[22:21] = p.red[3:2];
      w[24:23] = p.green[3:2];
      w[26:25] = p.blue[3:2];
    end
    w[29:28] = p.red[1:0];
    w[31:30] = p.green[1:0];
    w[33:32] = p.blue[1:0];
    return w;
  endfunction

  function automatic qpv_pix_s qpv_unpack(input logic vesa, input qpv_word_t w);
    qpv_pix_s p;
    if (vesa)
    begin
      p.red = {w[22:21], w[5:0], w[29:28]};
      p.green = {w[24:23], w[11:7], w[6], w[31:30]};
      p.blue = {w[26:25], w[17:14], w[13:12], w[33:32]};
    end
    else
    begin
      p.red = {w[5:0], w[22:21], w[29:28]};
      p.green = {w[11:7], w[6], w[24:23], w[31:30]};
      p.blue = {w[17:14], w[13:12], w[26:25], w[33:32]};
    end
    return p;
  endfunction
endpackage

// >>> design/qpv_link_if.sv
`timescale 1ns/100ps
`include "qpv_defs.svh"
interface qpv_link_if;
  logic [3:0] link_clk;
  logic [3:0][`QPV_WORD_W-1:0] link_word;
  logic format_select;
  logic rate_select;
  modport host (output link_clk, output link_word, output format_select,
                output rate_select);
  modport panel (input link_clk, input link_word, input format_select,
                 input rate_select);
endinterface

// >>> design/qpv_panel_rx.sv
`timescale 1ns/100ps
`include "qpv_defs.svh"
module qpv_fifo #(
  parameter int W = 31,
  parameter int D = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(D);
  typedef struct packed {
    logic [AW:0] wp;
    logic [AW:0] rp;
  } qpv_fifo_s;
  qpv_fifo_s f_reg;
  qpv_fifo_s f_next;
  logic [W-1:0] mem [D];
  logic wr;
  logic rd;

  assign in_ready = (f_reg.wp ^ f_reg.rp) != {1'b1, {AW{1'b0}}};
  assign out_valid = f_reg.wp != f_reg.rp;
  assign out_data = mem[f_reg.rp[AW-1:0]];
  assign wr = in_valid & in_ready;
  assign rd = out_valid & out_ready;

  always_comb
  begin
    f_next = f_reg;
    if (wr)
      f_next.wp = f_reg.wp + 1'b1;
    if (rd)
      f_next.rp = f_reg.rp + 1'b1;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      f_reg <= '0;
    else
      f_reg <= f_next;
  end

  always_ff @(posedge clk)
  begin
    if (wr)
      mem[f_reg.wp[AW-1:0]] <= in_data;
  end
endmodule // qpv_fifo

module qpv_panel_rx
  import qpv_pkg::*;
#(
  parameter int LOW_MIN_CYC = (`QPV_CLK_HZ + `QPV_LOW_RATE_MAX_HZ - 1) / `QPV_LOW_RATE_MAX_HZ,
  parameter int LOW_MAX_CYC = `QPV_CLK_HZ / `QPV_LOW_RATE_MIN_HZ,
  parameter int HIGH_MIN_CYC = (`QPV_CLK_HZ + `QPV_HIGH_RATE_MAX_HZ - 1) / `QPV_HIGH_RATE_MAX_HZ,
  parameter int HIGH_MAX_CYC = `QPV_CLK_HZ / `QPV_HIGH_RATE_MIN_HZ
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Link from the timing source
  qpv_link_if.panel link,
  // Pixel stream out
  input wire logic out_ready,
  output logic pix_valid,
  output logic [`QPV_CODE_W-1:0] pix_red,
  output logic [`QPV_CODE_W-1:0] pix_green,
  output logic [`QPV_CODE_W-1:0] pix_blue,
  output logic [10:0] pix_x,
  output logic [10:0] pix_y,
  output logic pix_sof,
  // Status
  output logic overflow,
  output logic rate_error
);
  localparam qpv_rx_s RX_RST = '{fmt_q: 1'b1, rate_q: 1'b1, default: '0};
  qpv_rx_s r_reg;
  qpv_rx_s r_next;
  logic [3:0] agree;
  logic [3:0] cap;
  logic [3:0] push;
  logic [3:0] in_rdy;
  logic [3:0] o_vld;
  logic [3:0] pop;
  logic [3:0][30:0] wdat;
  logic [3:0][30:0] o_dat;
  logic sof_evt;
  logic take;
  logic [21:0] lo;
  logic [21:0] hi;

  // ----------------------------------------------------------------
  // Edge detect and per-port buffering
  // ----------------------------------------------------------------
  assign agree = ~(r_reg.ck2 ^ r_reg.ck3);
  assign cap = agree & r_reg.ck3 & ~r_reg.ckq;
  // Only the port carrying pixel one marks a frame start.
  assign sof_evt = push[0] & r_reg.vblank;

  genvar g;
  generate
    for (g = 0; g < `QPV_PORTS; g++)
    begin : g_port
      assign push[g] = cap[g] & r_reg.d3[g][`QPV_PV_BIT];
      assign wdat[g] = {(g == 0) & sof_evt, qpv_unpack(r_reg.fmt_q, r_reg.d3[g])};
      qpv_fifo #(.W(31), .D(`QPV_FIFO_DEPTH)) u_fifo (
        .clk(clk),
        .arst_n(arst_n),
        .in_valid(push[g]),
        .in_ready(in_rdy[g]),
        .in_data(wdat[g]),
        .out_valid(o_vld[g]),
        .out_ready(pop[g]),
        .out_data(o_dat[g])
      );
    end
  endgenerate

  // Ports are drained 1,2,3,4,1,... to rebuild line order.
  assign take = o_vld[r_reg.rr] & (~r_reg.vld | out_ready);
  assign pop = take ? 4'(4'h1 << r_reg.rr) : 4'h0;
  assign lo = r_reg.rate_q ? 22'(LOW_MIN_CYC) : 22'(HIGH_MIN_CYC);
  assign hi = r_reg.rate_q ? 22'(LOW_MAX_CYC) : 22'(HIGH_MAX_CYC);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    r_next = r_reg;
    r_next.ck1 = link.link_clk;
    r_next.ck2 = r_reg.ck1;
    r_next.ck3 = r_reg.ck2;
    r_next.ckq = (agree & r_reg.ck3) | (~agree & r_reg.ckq);
    r_next.d1 = link.link_word;
    r_next.d2 = r_reg.d1;
    r_next.d3 = r_reg.d2;
    r_next.fmt_s = {r_reg.fmt_s[1:0], link.format_select};
    r_next.rate_s = {r_reg.rate_s[1:0], link.rate_select};
    if (r_reg.fmt_s[1] == r_reg.fmt_s[2])
      r_next.fmt_q = r_reg.fmt_s[2];
    if (r_reg.rate_s[1] == r_reg.rate_s[2])
      r_next.rate_q = r_reg.rate_s[2];
    // A blank run longer than any line blank means vertical blanking.
    if (cap[0])
    begin
      if (r_reg.d3[0][`QPV_PV_BIT])
      begin
        r_next.blank = '0;
        r_next.vblank = 1'b0;
      end
      else
      begin
        if (r_reg.blank != 8'hFF)
          r_next.blank = r_reg.blank + 8'h01;
        if (r_reg.blank >= 8'(`QPV_HBLANK_MAX))
          r_next.vblank = 1'b1;
      end
    end
    if (r_reg.per != 22'h3FFFFF)
      r_next.per = r_reg.per + 22'h000001;
    if (sof_evt)
    begin
      r_next.per = '0;
      r_next.seen = 1'b1;
      if (r_reg.seen)
        r_next.rerr = (r_reg.per < lo) | (r_reg.per > hi);
    end
    r_next.ovf = (r_reg.ovf & ~sof_evt) | |(push & ~in_rdy);
    if (take)
    begin
      r_next.vld = 1'b1;
      // Codes pass unchanged, so a larger code stays brighter.
      r_next.pix = o_dat[r_reg.rr][29:0];
      r_next.sof = o_dat[r_reg.rr][30];
      r_next.rr = r_reg.rr + 2'h1;
      if (o_dat[r_reg.rr][30])
      begin
        r_next.x = '0;
        r_next.y = '0;
      end
      else if (r_reg.x == 11'(`QPV_LINE_PIX - 1))
      begin
        r_next.x = '0;
        r_next.y = (r_reg.y == 11'(`QPV_ACT_LINES - 1)) ? '0 : r_reg.y + 11'h001;
      end
      else
        r_next.x = r_reg.x + 11'h001;
    end
    else if (out_ready)
      r_next.vld = 1'b0;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      r_reg <= RX_RST;
    else
      r_reg <= r_next;
  end

  assign pix_valid = r_reg.vld;
  assign pix_red = r_reg.pix.red;
  assign pix_green = r_reg.pix.green;
  assign pix_blue = r_reg.pix.blue;
  assign pix_x = r_reg.x;
  assign pix_y = r_reg.y;
  assign pix_sof = r_reg.sof;
  assign overflow = r_reg.ovf;
  assign rate_error = r_reg.rerr;
endmodule // qpv_panel_rx

// >>> design/qpv_host_tx.sv
`timescale 1ns/100ps
`include "qpv_defs.svh"
// Behaviour
// - Port k carries pixels k, k+4, k+8.
// - Four ports, each clock plus five pairs.
// - Format pin high or open selects VESA.
// - Reserved no-connect pins stay undriven.
// - Each primary is a 10-bit code.
// - Larger code gives brighter sub-pixel.
// - Bit 9 is MSB, bit 0 LSB.
// - One is high level, zero low.
// - Link clock between 60 and 80 MHz; the code divides clk by 16, giving 12.5 MHz.
// - Totals keep clock within limits per rate.
// - Spread clock within 2%, 200 kHz.
// - Rate pin selects 100 or 120 Hz.
// - Frame: 1080 active plus 35-55 blank lines.
// - Line: 480 active plus 60-95 blank clocks.
// - Timing comes from data enable only.
// - Sync bit positions always held low.
// - Supply off: all inputs low or floating.
// - Never drive signals before supply is valid.
// - Supply on: drive every signal actively.
// - Backlight on after start, off before stop; on supply loss the code drops it in the same cycle as the link.
module qpv_host_tx
  import qpv_pkg::*;
#(
  parameter int H_BLANK = `QPV_HBLANK_NOM,
  parameter int V_BLANK = `QPV_VBLANK_NOM
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Link to the panel
  qpv_link_if.host link,
  // Control
  input wire logic supply_on,
  input wire logic run,
  input wire logic cfg_vesa,
  input wire logic cfg_rate_100,
  // Pixel source
  input wire logic src_valid,
  input wire logic [`QPV_CODE_W-1:0] src_red,
  input wire logic [`QPV_CODE_W-1:0] src_green,
  input wire logic [`QPV_CODE_W-1:0] src_blue,
  output logic src_ready,
  // Status
  output logic underrun,
  output logic frame_start,
  output logic backlight_en
);
  localparam logic [9:0] LINE_TOTAL = 10'(`QPV_LINE_ACT_CLK + H_BLANK);
  localparam logic [10:0] FRAME_TOTAL = 11'(`QPV_ACT_LINES + V_BLANK);
  localparam logic [3:0] HALF = 4'(`QPV_LINK_DIV / 2);
  // The divider rests at its last count while off, so the first high phase is full length.
  localparam qpv_tx_s TX_RST = '{mode: QPV_OFF, div: 4'(`QPV_LINK_DIV - 1), default: '0};

  qpv_tx_s t_reg;
  qpv_tx_s t_next;
  logic launch;
  logic pv;
  logic full;
  qpv_pix_s src_pix;

  // ----------------------------------------------------------------
  // Link clock divider
  // ----------------------------------------------------------------
  // The link clock is a divided copy of clk; its rate scales with clk.
  assign launch = (t_reg.div == HALF - 4'h1);
  assign pv = (t_reg.h < 10'(`QPV_LINE_ACT_CLK)) &&
              (t_reg.v < 11'(`QPV_ACT_LINES));
  assign full = (t_reg.fill == 3'h4);
  assign src_pix = '{red: src_red, green: src_green, blue: src_blue};

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    t_next = t_reg;
    t_next.fpulse = 1'b0;
    if (t_reg.div == 4'(`QPV_LINK_DIV - 1))
      t_next.div = '0;
    else
      t_next.div = t_reg.div + 4'h1;
    t_next.lclk = (t_next.div < HALF);

    case (t_reg.mode)
      QPV_OFF:
      begin
        if (supply_on)
          t_next.mode = QPV_IDLE;
      end
      QPV_IDLE:
      begin
        if (!supply_on)
          t_next.mode = QPV_OFF;
        else if (run)
        begin
          t_next.mode = QPV_RUN;
          t_next.urun = 1'b0;
          t_next.h = '0;
          // Start in vertical blanking so the panel sees a frame edge.
          t_next.v = 11'(`QPV_ACT_LINES);
        end
      end
      QPV_RUN:
      begin
        if (!supply_on)
          t_next.mode = QPV_OFF;
        else if (!run && !t_reg.bl)
          t_next.mode = QPV_IDLE;
      end
      default:
        t_next.mode = QPV_OFF;
    endcase

    // Backlight drops a cycle ahead of a run stop, in the same cycle as the link on supply loss, and rises after a frame start.
    if (!run || !supply_on)
      t_next.bl = 1'b0;
    else if (t_reg.fpulse)
      t_next.bl = 1'b1;

    if (src_valid && t_reg.rdy)
    begin
      t_next.grp[t_reg.fill[1:0]] = src_pix;
      t_next.fill = t_reg.fill + 3'h1;
    end

    if (launch && t_reg.mode == QPV_RUN && t_next.mode == QPV_RUN)
    begin
      for (int k = 0; k < `QPV_PORTS; k++)
        t_next.word[k] = qpv_pack(cfg_vesa, (pv && full) ? t_reg.grp[k] : '0, pv);
      if (pv)
      begin
        if (!full)
          t_next.urun = 1'b1;
        t_next.fill = '0;
      end
      t_next.fpulse = (t_reg.h == '0) && (t_reg.v == '0);
      if (t_reg.h == LINE_TOTAL - 10'h001)
      begin
        t_next.h = '0;
        t_next.v = (t_reg.v == FRAME_TOTAL - 11'h001) ? '0 : t_reg.v + 11'h001;
      end
      else
        t_next.h = t_reg.h + 10'h001;
    end
    else if (launch)
      t_next.word = '0;

    if (t_next.mode == QPV_OFF)
    begin
      t_next.lclk = 1'b0;
      t_next.div = 4'(`QPV_LINK_DIV - 1);
      t_next.word = '0;
      t_next.fmt_o = 1'b0;
      t_next.rate_o = 1'b0;
      t_next.fill = '0;
    end
    else
    begin
      t_next.fmt_o = cfg_vesa;
      t_next.rate_o = cfg_rate_100;
    end
    // No take in the launch cycle, so a group is never split.
    t_next.rdy = (t_next.mode == QPV_RUN) && (t_next.fill < 3'h4) &&
                 (t_next.div != HALF - 4'h1);
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      t_reg <= TX_RST;
    else
      t_reg <= t_next;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Only defined pins exist on the link; reserved ones are left open.
  assign link.link_clk = {4{t_reg.lclk}};
  assign link.link_word = t_reg.word;
  assign link.format_select = t_reg.fmt_o;
  assign link.rate_select = t_reg.rate_o;
  assign src_ready = t_reg.rdy;
  assign underrun = t_reg.urun;
  assign frame_start = t_reg.fpulse;
  assign backlight_en = t_reg.bl;
endmodule // qpv_host_tx

// >>> testbench/qpv_link_assertions.sv
`timescale 1ns/100ps
`include "qpv_defs.svh"
module qpv_link_assertions (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Link signals
  input wire logic [3:0] link_clk,
  input wire logic [3:0][`QPV_WORD_W-1:0] link_word,
  input wire logic format_select,
  input wire logic rate_select
);
  // ----------------------------------------------------------------
  // Run-length helpers
  // ----------------------------------------------------------------
  // Words are judged in the same cycle the link clock is first seen high, when the sampled word is settled.
  logic lc_reg;
  logic pv_reg;
  logic [15:0] act_reg;
  logic [15:0] blk_reg;
  logic rise;
  logic pv;
  logic [3:0] sync_bits;
  logic [3:0] spare_bits;
  logic [3:0] pv_bits;
  assign rise = link_clk[0] & ~lc_reg;
  assign pv = link_word[0][`QPV_PV_BIT];
  always_comb
  begin
    for (int k = 0; k < 4; k++)
    begin
      sync_bits[k] = link_word[k][`QPV_VS_BIT] | link_word[k][`QPV_HS_BIT];
      spare_bits[k] = link_word[k][27] | link_word[k][34];
      pv_bits[k] = link_word[k][`QPV_PV_BIT];
    end
  end
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      lc_reg <= 1'b0;
      pv_reg <= 1'b0;
      act_reg <= 16'h0000;
      blk_reg <= 16'h0000;
    end
    else
    begin
      lc_reg <= link_clk[0];
      if (rise)
      begin
        pv_reg <= pv;
        act_reg <= pv ? ((pv_reg ? act_reg : 16'h0000) + 16'h0001) : act_reg;
        blk_reg <= pv ? blk_reg : ((pv_reg ? 16'h0000 : blk_reg) + 16'h0001);
      end
    end
  end
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  sequence lclk_high;
    link_clk[0] [*7];
  endsequence
  sequence lclk_low;
    !link_clk[0] [*8];
  endsequence
  sequence pv_fall;
    rise && !pv && pv_reg;
  endsequence
  sequence pv_rise;
    rise && pv && !pv_reg;
  endsequence
  chk_clk_period: assert property
    ($rose(link_clk[0]) |=> lclk_high ##1 lclk_low ##1 link_clk[0])
    else $error("link clock period wrong");
  chk_clk_ports: assert property (link_clk == {4{link_clk[0]}})
    else $error("port clocks differ");
  chk_word_launch: assert property
    ($changed(link_word) |-> $fell(link_clk[0]) || link_word == '0)
    else $error("word changed off the falling link edge");
  chk_sync_low: assert property (sync_bits == 4'h0)
    else $error("sync position not low");
  chk_spare_low: assert property (spare_bits == 4'h0)
    else $error("spare position driven");
  chk_enable_aligned: assert property (pv_bits == 4'h0 || pv_bits == 4'hF)
    else $error("ports disagree on enable");
  chk_active_count: assert property (pv_fall |-> act_reg == 16'h01E0)
    else $error("active clocks per line wrong");
  chk_blank_min: assert property (pv_rise |-> blk_reg >= 16'h003C)
    else $error("line blank too short");
  chk_pins_steady: assert property
    (pv |-> $stable(format_select) && $stable(rate_select))
    else $error("select pins moved during active data");
  cover property (pv_rise);
endmodule // qpv_link_assertions

// >>> testbench/testbench.sv
`timescale 1ns/100ps
`include "qpv_defs.svh"
module testbench
  import qpv_pkg::*;
;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic supply_on = 1'b0;
  logic run = 1'b0;
  logic cfg_vesa = 1'b1;
  logic cfg_rate_100 = 1'b1;
  logic src_valid = 1'b0;
  logic [29:0] src_rgb = 30'h00000000;
  logic out_ready = 1'b0;
  logic src_ready, underrun, frame_start, backlight_en;
  logic pix_valid, pix_sof, overflow, rate_error;
  logic [9:0] pix_red, pix_green, pix_blue;
  logic [10:0] pix_x, pix_y;
  logic sink_on = 1'b1;
  logic [29:0] pix_rgb;
  logic [31:0] seed = 32'h0000EADE;
  logic feed = 1'b0;
  logic took = 1'b0;
  logic watch = 1'b0;
  int err_count = 0;
  int n_compared = 0;
  int n_pix = 0;
  int n_src = 0;
  int n_frames = 0;
  logic [29:0] exp_q[$];
  // White, black, top bit only and bottom bit only on every primary lead the stream.
  logic [29:0] corner [4] = '{30'h3FFFFFFF, 30'h00000000, 30'h20080200, 30'h00100401};

  always #2.5 clk = ~clk;

  qpv_link_if qpv_link_if_i ();
  qpv_host_tx #(.H_BLANK(60), .V_BLANK(2)) qpv_host_tx_i (.clk(clk), .arst_n(arst_n),
    .link(qpv_link_if_i.host), .supply_on(supply_on), .run(run), .cfg_vesa(cfg_vesa),
    .cfg_rate_100(cfg_rate_100), .src_valid(src_valid), .src_red(src_rgb[29:20]),
    .src_green(src_rgb[19:10]), .src_blue(src_rgb[9:0]), .src_ready(src_ready),
    .underrun(underrun), .frame_start(frame_start), .backlight_en(backlight_en));
  qpv_panel_rx qpv_panel_rx_i (.clk(clk), .arst_n(arst_n), .link(qpv_link_if_i.panel),
    .out_ready(out_ready), .pix_valid(pix_valid), .pix_red(pix_red), .pix_green(pix_green),
    .pix_blue(pix_blue), .pix_x(pix_x), .pix_y(pix_y), .pix_sof(pix_sof),
    .overflow(overflow), .rate_error(rate_error));
  assign pix_rgb = {pix_red, pix_green, pix_blue};
  qpv_link_assertions qpv_link_assertions_i (.clk(clk), .arst_n(arst_n),
    .link_clk(qpv_link_if_i.link_clk), .link_word(qpv_link_if_i.link_word),
    .format_select(qpv_link_if_i.format_select), .rate_select(qpv_link_if_i.rate_select));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] r;
    r = s ^ (s << 13);
    r = r ^ (r >> 17);
    r = r ^ (r << 5);
    return r;
  endfunction

  function automatic logic [31:0] exp_pos(input int n);
    return {5'h00, 11'(n / `QPV_LINE_PIX), 5'h00, 11'(n % `QPV_LINE_PIX)};
  endfunction

  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      err_count++;
    end
  endtask

  task stop_test;
    if (err_count == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Source and sink drivers
  // ----------------------------------------------------------------
  // One process draws every random value so the sequence never depends on process order.
  always @(negedge clk)
  begin
    seed = xs(seed);
    out_ready <= sink_on && seed[3:2] != 2'b00;
    if (!feed)
      src_valid <= 1'b0;
    else if (!src_valid || took)
    begin
      src_valid <= seed[6:4] != 3'h0;
      src_rgb <= (n_src < 4) ? corner[n_src] : 30'(xs(seed));
    end
    took = 1'b0;
  end

  always @(posedge clk)
  begin
    if (src_valid && src_ready)
    begin
      exp_q.push_back(src_rgb);
      n_src++;
      took = 1'b1;
    end
    if (frame_start)
      n_frames++;
    if (watch && pix_valid && out_ready)
    begin
      check({2'b00, pix_rgb}, {2'b00, exp_q.pop_front()});
      check({5'h00, pix_y, 5'h00, pix_x}, exp_pos(n_pix));
      check(pix_sof, n_pix == 0);
      n_pix++;
    end
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Every scenario starts from a held reset with the supply off.
  task restart(input logic vesa, input logic rate);
    arst_n = 1'b0;
    feed = 1'b0;
    watch = 1'b0;
    run = 1'b0;
    supply_on = 1'b0;
    cfg_vesa = vesa;
    cfg_rate_100 = rate;
    repeat (12) @(negedge clk);
    exp_q.delete();
    n_pix = 0;
    n_src = 0;
    n_frames = 0;
    arst_n = 1'b1;
  endtask

  task do_run(input logic vesa, input logic rate);
    int k;
    restart(vesa, rate);
    repeat (4) @(negedge clk);
    check(qpv_link_if_i.link_clk, 4'h0);
    check(|qpv_link_if_i.link_word, 1'b0);
    supply_on = 1'b1;
    repeat (4) @(negedge clk);
    check(qpv_link_if_i.format_select, vesa);
    check(qpv_link_if_i.rate_select, rate);
    check(backlight_en, 1'b0);
    run = 1'b1;
    feed = 1'b1;
    watch = 1'b1;
    for (k = 0; k < 40000 && n_pix < `QPV_LINE_PIX + 8; k++)
      @(negedge clk);
    check(n_pix, `QPV_LINE_PIX + 8);
    check(n_frames, 1);
    check(backlight_en, 1'b1);
    check(underrun, 1'b0);
    check(overflow, 1'b0);
    check(rate_error, 1'b0);
  endtask

  // With the sink stalled the port buffers fill until a push is dropped; the first pixel stands.
  task stall_test;
    int k;
    sink_on = 1'b0;
    restart(1'b1, 1'b1);
    supply_on = 1'b1;
    run = 1'b1;
    feed = 1'b1;
    for (k = 0; k < 20000 && overflow !== 1'b1; k++)
      @(negedge clk);
    check(overflow, 1'b1);
    check(pix_valid, 1'b1);
    check({9'h000, pix_sof, pix_y, pix_x}, 32'h00400000);
    check({2'b00, pix_rgb}, {2'b00, corner[0]});
    sink_on = 1'b1;
  endtask

  initial
  begin
    do_run(1'b1, 1'b1);
    stall_test;
    do_run(1'b0, 1'b0);
    stop_test;
  end

  initial
  begin
    repeat (90000) @(posedge clk);
    err_count++;
    stop_test;
  end
endmodule // testbench
